// file: hw/flash_prog_host.sv
`timescale 1ns/100ps
// Function
// - erase: write pattern X0000011, store strobe within four cycles.
// - word load: pattern 00000001, store within four cycles, pointer and data set.
// - each buffer word loaded only once between clears.
// - page write: pattern X0000101, store within four cycles.
// - page write pointer holds page only, other bits zero.
// - erase and write of one update use the same page.
// - rww busy flag stays until re-enable bit written.
// - lock write: data in low register, pattern X0001001, store within four.
// - lock write pointer 0x0001, data bits 7 and 6 set.
// - check eeprom busy clear before writing control register.
// - lock read: pointer 0x0001, lock set and enable, then load.
module flash_prog_host #(
    parameter int WORD_BITS = flash_prog_pkg::RESET_WORDS,
    parameter int OP_MAX    = flash_prog_pkg::OP_MAX_CYC
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    output flash_prog_pkg::dev_out_t      dev_o,
    input  wire logic [7:0]               ctl_rd,
    input  wire logic [7:0]               load_data,
    input  wire logic                     eeprom_write_busy
);
    localparam int WORDS = 1 << WORD_BITS;

    flash_prog_pkg::state_t   state_q;
    flash_prog_pkg::dev_out_t dev_q;
    logic [2:0]       op_q;
    logic [15:0]      ptr_q;
    logic [15:0]      data_q;
    logic [7:0]       rdata_q;
    logic             done_q;
    logic             err_dup_q;
    logic             err_page_q;
    logic             err_tmo_q;
    logic [16:0]      cnt_q;
    logic [WORDS-1:0] loaded_q;
    logic [WORDS-1:0] clr_mask;
    logic [15:0]      erase_page_q;
    logic             erase_vld_q;
    logic [7:0]       ctl_m_q;
    logic [7:0]       ctl_s_q;
    logic [7:0]       ld_m_q;
    logic [7:0]       ld_s_q;
    logic             ee_m_q;
    logic             ee_s_q;
    logic             pready_q;
    logic [31:0]      prdata_q;
    logic             wr_acc;
    logic             start;
    logic [WORD_BITS-1:0] widx;
    logic [15:0]      page_of_ptr;
    logic             clr_buf;

    // ==========================================================
    // pin input synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_m_q <= 8'h00;
            ctl_s_q <= 8'h00;
            ld_m_q  <= 8'h00;
            ld_s_q  <= 8'h00;
            ee_m_q  <= 1'b0;
            ee_s_q  <= 1'b0;
        end
        else
        begin
            ctl_m_q <= ctl_rd;
            ctl_s_q <= ctl_m_q;
            ld_m_q  <= load_data;
            ld_s_q  <= ld_m_q;
            ee_m_q  <= eeprom_write_busy;
            ee_s_q  <= ee_m_q;
        end
    end

    // ==========================================================
    // apb slave, no wait state, registered answer
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign start  = wr_acc && (paddr == flash_prog_pkg::OFS_CMD)
                    && (state_q == flash_prog_pkg::S_IDLE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= psel && !penable;
            prdata_q <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    flash_prog_pkg::OFS_CMD:  prdata_q <= {29'h0, op_q};
                    flash_prog_pkg::OFS_PTR:  prdata_q <= {16'h0, ptr_q};
                    flash_prog_pkg::OFS_DATA: prdata_q <= {16'h0, data_q};
                    flash_prog_pkg::OFS_STAT: prdata_q <= {16'h0, rdata_q, 2'h0,
                        ctl_s_q[flash_prog_pkg::BIT_RWWB], err_tmo_q, err_page_q,
                        err_dup_q, done_q, (state_q != flash_prog_pkg::S_IDLE)};
                    default:                  prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // pointer and data registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_q  <= 16'h0000;
            data_q <= 16'h0000;
        end
        else if (wr_acc && paddr == flash_prog_pkg::OFS_PTR)
            ptr_q  <= pwdata[15:0];
        else if (wr_acc && paddr == flash_prog_pkg::OFS_DATA)
            data_q <= pwdata[15:0];
    end

    // ==========================================================
    // loaded-word bookkeeping
    assign widx        = ptr_q[WORD_BITS:1];
    assign page_of_ptr = ptr_q & ~16'((1 << (WORD_BITS + 1)) - 1);
    assign clr_buf     = (state_q == flash_prog_pkg::S_DONE && !err_tmo_q
                          && (op_q == flash_prog_pkg::OP_WRITE
                              || op_q == flash_prog_pkg::OP_REEN))
                         || ee_s_q;

    generate
        for (genvar i = 0; i < WORDS; i++)
        begin : g_word
            assign clr_mask[i] = clr_buf;
            // one flag per buffer word, any order
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    loaded_q[i] <= 1'b0;
                else if (clr_mask[i])
                    loaded_q[i] <= 1'b0;
                else if (dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_LOAD
                         && dev_q.ptr[WORD_BITS:1] == WORD_BITS'(i))
                    loaded_q[i] <= 1'b1;
            end
        end
    endgenerate

    // erased page memory for the later page write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            erase_page_q <= 16'h0000;
            erase_vld_q  <= 1'b0;
        end
        else if (start && pwdata[2:0] == flash_prog_pkg::OP_ERASE)
        begin
            erase_page_q <= page_of_ptr;
            erase_vld_q  <= 1'b1;
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= flash_prog_pkg::S_IDLE;
            op_q       <= 3'h0;
            cnt_q      <= 17'h00000;
            done_q     <= 1'b0;
            err_dup_q  <= 1'b0;
            err_page_q <= 1'b0;
            err_tmo_q  <= 1'b0;
            rdata_q    <= 8'hFF;
        end
        else
        begin
            case (state_q)
                flash_prog_pkg::S_IDLE:
                begin
                    if (start)
                    begin
                        op_q       <= pwdata[2:0];
                        done_q     <= 1'b0;
                        err_dup_q  <= 1'b0;
                        err_page_q <= 1'b0;
                        err_tmo_q  <= 1'b0;
                        if (pwdata[2:0] == flash_prog_pkg::OP_LOAD && loaded_q[widx])
                        begin
                            err_dup_q <= 1'b1;
                            done_q    <= 1'b1;
                        end
                        else if (pwdata[2:0] == flash_prog_pkg::OP_WRITE
                                 && (!erase_vld_q || erase_page_q != page_of_ptr))
                        begin
                            err_page_q <= 1'b1;
                            done_q     <= 1'b1;
                        end
                        else
                            state_q <= flash_prog_pkg::S_CHKEE;
                    end
                end
                flash_prog_pkg::S_CHKEE:
                    if (!ee_s_q)
                        state_q <= flash_prog_pkg::S_CTL;
                flash_prog_pkg::S_CTL:
                    state_q <= flash_prog_pkg::S_ISSUE;
                flash_prog_pkg::S_ISSUE:
                begin
                    cnt_q <= 17'h00000;
                    if (op_q == flash_prog_pkg::OP_LOCKR)
                        state_q <= flash_prog_pkg::S_RD;
                    else if (op_q == flash_prog_pkg::OP_LOAD)
                        state_q <= flash_prog_pkg::S_DONE;
                    else
                        state_q <= flash_prog_pkg::S_WAIT;
                end
                flash_prog_pkg::S_WAIT:
                begin
                    cnt_q <= cnt_q + 17'h00001;
                    if (cnt_q >= 17'(flash_prog_pkg::SETTLE_CYC)
                        && !ctl_s_q[flash_prog_pkg::BIT_SPE])
                        state_q <= flash_prog_pkg::S_DONE;
                    else if (cnt_q >= 17'(OP_MAX))
                    begin
                        err_tmo_q <= 1'b1;
                        state_q   <= flash_prog_pkg::S_DONE;
                    end
                end
                flash_prog_pkg::S_RD:
                begin
                    cnt_q <= cnt_q + 17'h00001;
                    if (cnt_q == 17'(flash_prog_pkg::RDLAT_CYC))
                    begin
                        rdata_q <= ld_s_q;
                        state_q <= flash_prog_pkg::S_DONE;
                    end
                end
                flash_prog_pkg::S_DONE:
                begin
                    done_q  <= 1'b1;
                    state_q <= flash_prog_pkg::S_IDLE;
                end
                default:
                    state_q <= flash_prog_pkg::S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // device pins, driven from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dev_q <= '0;
        else
        begin
            dev_q.ctl_wr <= (state_q == flash_prog_pkg::S_CHKEE) && !ee_s_q;
            dev_q.store  <= (state_q == flash_prog_pkg::S_CTL)
                            && (op_q != flash_prog_pkg::OP_LOCKR);
            dev_q.load   <= (state_q == flash_prog_pkg::S_CTL)
                            && (op_q == flash_prog_pkg::OP_LOCKR);
            if (state_q == flash_prog_pkg::S_CHKEE)
            begin
                dev_q.ptr     <= ptr_q;
                dev_q.data_hi <= data_q[15:8];
                dev_q.data_lo <= data_q[7:0];
                case (op_q)
                    flash_prog_pkg::OP_LOAD:  dev_q.ctl_data <= flash_prog_pkg::PAT_LOAD;
                    flash_prog_pkg::OP_ERASE: dev_q.ctl_data <= flash_prog_pkg::PAT_ERASE;
                    flash_prog_pkg::OP_WRITE:
                    begin
                        dev_q.ctl_data <= flash_prog_pkg::PAT_WRITE;
                        dev_q.ptr      <= page_of_ptr;
                    end
                    flash_prog_pkg::OP_LOCKW, flash_prog_pkg::OP_LOCKR:
                    begin
                        dev_q.ctl_data <= flash_prog_pkg::PAT_LOCK;
                        dev_q.ptr      <= flash_prog_pkg::LOCK_PTR;
                        dev_q.data_lo  <= {flash_prog_pkg::LOCK_HI, data_q[5:0]};
                    end
                    default:                  dev_q.ctl_data <= flash_prog_pkg::PAT_REEN;
                endcase
            end
        end
    end

    assign dev_o   = dev_q;
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = 1'b0;

    // ==========================================================
    // assertions
    a_store_follows_ctl: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.store |-> $past(dev_q.ctl_wr)) else $error("store without control write");
    a_ctl_gets_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.ctl_wr |=> (dev_q.store || dev_q.load)) else $error("control write not followed");
    a_write_ptr_page: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_WRITE
        |-> dev_q.ptr[WORD_BITS:0] == '0) else $error("page write pointer not clean");
    a_lock_write_ptr: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_LOCK
        |-> dev_q.ptr == 16'h0001 && dev_q.data_lo[7:6] == 2'h3)
        else $error("lock write pointer or data wrong");
    a_lock_read_seq: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.load |-> dev_q.ptr == 16'h0001 && $past(dev_q.ctl_wr)
        && dev_q.ctl_data == 8'h09) else $error("lock read sequence wrong");
    a_eeprom_idle: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.ctl_wr |-> !$past(ee_s_q)) else $error("control write while eeprom busy");
    a_no_dup_load: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_LOAD
        |-> !loaded_q[dev_q.ptr[WORD_BITS:1]]) else $error("buffer word loaded twice");
    a_same_page: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_WRITE
        |-> dev_q.ptr == erase_page_q) else $error("write page differs from erase");
    a_reen_clears: assert property (@(posedge pclk) disable iff (!presetn)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_REEN
        |-> ##[1:100] (state_q == flash_prog_pkg::S_DONE) ##1 loaded_q == '0)
        else $error("re-enable did not clear loaded words");
    c_erase: cover property (@(posedge pclk)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_ERASE);
    c_page_write: cover property (@(posedge pclk)
        dev_q.store && dev_q.ctl_data == flash_prog_pkg::PAT_WRITE);
    c_lock_read: cover property (@(posedge pclk) dev_q.load ##6 done_q);
    c_timeout: cover property (@(posedge pclk) $rose(err_tmo_q));
endmodule // flash_prog_host

// file: hw/flash_prog_pkg.sv
package flash_prog_pkg;
    // ==========================================================
    // register offsets and status fields
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_PTR     = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h08;
    localparam logic [7:0] OFS_STAT    = 8'h0C;
    localparam int         ST_BUSY     = 0;
    localparam int         ST_DONE     = 1;
    localparam int         ST_ERR_DUP  = 2;
    localparam int         ST_ERR_PAGE = 3;
    localparam int         ST_ERR_TMO  = 4;
    localparam int         ST_RWW      = 5;
    localparam int         ST_RDATA    = 8;
    // ==========================================================
    // operations and control byte patterns
    localparam logic [2:0] OP_LOAD  = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_LOCKW = 3'h4;
    localparam logic [2:0] OP_LOCKR = 3'h5;
    localparam logic [2:0] OP_REEN  = 3'h6;
    localparam logic [7:0] PAT_LOAD  = 8'h01;
    localparam logic [7:0] PAT_ERASE = 8'h03;
    localparam logic [7:0] PAT_WRITE = 8'h05;
    localparam logic [7:0] PAT_LOCK  = 8'h09;
    localparam logic [7:0] PAT_REEN  = 8'h11;
    localparam int         BIT_SPE   = 0;
    localparam int         BIT_RWWB  = 6;
    localparam logic [15:0] LOCK_PTR  = 16'h0001;
    localparam logic [1:0]  LOCK_HI   = 2'h3;
    // ==========================================================
    // timing
    localparam int CLK_NS      = 50;
    localparam int OP_MAX_US   = 4500;
    localparam int OP_MAX_CYC  = OP_MAX_US * 1000 / CLK_NS;
    localparam int SETTLE_CYC  = 4;
    localparam int RDLAT_CYC   = 3;
    localparam int RESET_WORDS = 6;
    // ==========================================================
    // sequencer states and pin bundle
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_CHKEE = 7'h02,
        S_CTL   = 7'h04,
        S_ISSUE = 7'h08,
        S_WAIT  = 7'h10,
        S_RD    = 7'h20,
        S_DONE  = 7'h40
    } state_t;
    typedef struct packed {
        logic        ctl_wr;
        logic [7:0]  ctl_data;
        logic        store;
        logic        load;
        logic [15:0] ptr;
        logic [7:0]  data_hi;
        logic [7:0]  data_lo;
    } dev_out_t;
endpackage

// file: bench/flash_dev_model.sv
`timescale 1ns/100ps
// ==========================================================
// flash device seen through its control pins
module flash_dev_model #(
    parameter int OP_CYC = 30
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  flash_prog_pkg::dev_out_t dev_i,
    input  wire logic                ee_busy,
    output logic [7:0]               ctl_rd,
    output logic [7:0]               load_data
);
    logic [7:0]  ctl_q;
    logic [2:0]  win_q;
    int          cnt_q;
    logic        rww_q;
    logic [5:0]  lock_q;
    logic [7:0]  ld_q;
    logic [8:0]  erase_pg_q;
    logic [15:0] wr_ptr_q;
    logic [15:0] lk_ptr_q;
    logic [7:0]  lk_lo_q;
    int          n_store_q;
    logic [15:0] buf_q [64];
    logic        prog_done_irq;

    // completion interrupt stands while the enable bit reads clear
    assign prog_done_irq = !ctl_q[0];

    // enable and command bits read back with the busy flag
    assign ctl_rd    = {1'b0, rww_q, ctl_q[5:0]};
    assign load_data = ld_q;

    // command window, operation timer, page buffer, lock cells
    always_ff @(posedge pclk or negedge presetn)
    begin : seq
        logic clr;
        clr = 1'b0;
        if (!presetn)
        begin
            ctl_q <= 8'h00;
            win_q <= 3'h0;
            cnt_q <= 0;
            rww_q <= 1'b0;
            lock_q <= 6'h3F;
            ld_q <= 8'hFF;
            n_store_q <= 0;
            clr = 1'b1;
        end
        else
        begin
            if (win_q != 3'h0) win_q <= win_q - 3'h1;
            if (win_q == 3'h1 && cnt_q == 0) ctl_q <= 8'h00;
            if (cnt_q != 0) cnt_q <= cnt_q - 1;
            if (cnt_q == 1) ctl_q <= 8'h00;
            if (cnt_q == 1 && ctl_q[2]) clr = 1'b1;
            if (ee_busy) clr = 1'b1;
            if (dev_i.ctl_wr && !ee_busy)
            begin
                ctl_q <= dev_i.ctl_data;
                win_q <= 3'h4;
            end
            if (dev_i.store) n_store_q <= n_store_q + 1;
            if (dev_i.store && win_q != 3'h0 && cnt_q == 0)
            begin
                win_q <= 3'h0;
                case (ctl_q)
                    8'h01: buf_q[dev_i.ptr[6:1]] <= {dev_i.data_hi, dev_i.data_lo};
                    8'h03: erase_pg_q <= dev_i.ptr[15:7];
                    8'h05: wr_ptr_q <= dev_i.ptr;
                    8'h09: lock_q <= lock_q & dev_i.data_lo[5:0];
                    8'h11: clr = 1'b1;
                    default: ctl_q <= 8'h00;
                endcase
                if (ctl_q == 8'h09) lk_ptr_q <= dev_i.ptr;
                if (ctl_q == 8'h09) lk_lo_q <= dev_i.data_lo;
                if (ctl_q == 8'h03 || ctl_q == 8'h05 || ctl_q == 8'h09)
                    cnt_q <= OP_CYC;
                if (ctl_q == 8'h03 || ctl_q == 8'h05) rww_q <= 1'b1;
                if (ctl_q == 8'h11) rww_q <= 1'b0;
                if (ctl_q == 8'h01 || ctl_q == 8'h11) ctl_q <= 8'h00;
            end
            if (dev_i.load && win_q > 3'h1 && ctl_q == 8'h09)
            begin
                ld_q <= {2'b11, lock_q};
                ctl_q <= 8'h00;
                win_q <= 3'h0;
            end
        end
        if (clr) for (int i = 0; i < 64; i++) buf_q[i] <= 16'hFFFF;
    end
endmodule // flash_dev_model

// file: bench/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// register level check of the self-program sequencer
module testbench;
    logic                     pclk;
    logic                     presetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [7:0]               paddr;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    flash_prog_pkg::dev_out_t dev;
    logic [7:0]               ctl_rd;
    logic [7:0]               load_data;
    logic                     ee_busy;
    logic [31:0]              r;
    int                       fail_count = 0;
    int                       checked = 0;
    int                       n;
    int                       wi [3] = '{5, 2, 9};
    logic [15:0]              dv [3] = '{16'hA55A, 16'h1234, 16'hBEEF};

    flash_prog_host #(.OP_MAX(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .dev_o(dev), .ctl_rd(ctl_rd), .load_data(load_data),
        .eeprom_write_busy(ee_busy));
    flash_dev_model #(.OP_CYC(30)) far (.pclk(pclk), .presetn(presetn), .dev_i(dev),
        .ee_busy(ee_busy), .ctl_rd(ctl_rd), .load_data(load_data));

    // ==========================================================
    // clock
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    // ==========================================================
    // tasks
    task automatic stop_test;
        $display("compares %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready and read data taken at the same rising edge
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(1'b0, 1'b1, "pready missing");
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic idle;
        int k;
        k = 0;
        do
        begin
            rd(flash_prog_pkg::OFS_STAT);
            k++;
        end while (r[flash_prog_pkg::ST_BUSY] !== 1'b0 && k < 100);
        if (k >= 100) chk(1'b0, 1'b1, "busy never cleared");
    endtask

    task automatic op(input logic [2:0] c);
        wr(flash_prog_pkg::OFS_CMD, {29'h0, c});
        idle();
    endtask

    // ==========================================================
    // watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test();
    end

    // ==========================================================
    // test sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ee_busy = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(flash_prog_pkg::OFS_STAT);
        chk(r, 32'h0000_FF00, "status after reset");
        rd(8'h10);
        chk(r, 32'h0, "unmapped read");
        $display("test reset done");
        // erase with word bits set in the pointer
        wr(flash_prog_pkg::OFS_PTR, 32'h0000_0154);
        op(flash_prog_pkg::OP_ERASE);
        chk(far.erase_pg_q, 32'h2, "erase page");
        chk(r[5:0], 6'h22, "status after erase");
        chk(far.prog_done_irq, 1'b1, "completion interrupt");
        // word loads out of order, then a repeat load
        for (int i = 0; i < 3; i++)
        begin
            wr(flash_prog_pkg::OFS_PTR, 32'h0000_0100 | (wi[i] << 1));
            wr(flash_prog_pkg::OFS_DATA, {16'h0, dv[i]});
            op(flash_prog_pkg::OP_LOAD);
            chk(far.buf_q[wi[i]], dv[i], "loaded word");
        end
        wr(flash_prog_pkg::OFS_PTR, 32'h0000_010A);
        wr(flash_prog_pkg::OFS_DATA, 32'h0000_7777);
        op(flash_prog_pkg::OP_LOAD);
        chk(r[flash_prog_pkg::ST_ERR_DUP], 1'b1, "dup flag");
        chk(far.buf_q[5], 16'hA55A, "dup not sent");
        // eeprom write forgets loaded words
        ee_busy <= 1'b1;
        repeat (4) @(posedge pclk);
        ee_busy <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(flash_prog_pkg::OFS_DATA, 32'h0000_0F0F);
        op(flash_prog_pkg::OP_LOAD);
        chk(far.buf_q[5], 16'h0F0F, "reload after eeprom");
        $display("test erase and load done");
        // write to a page other than the erased one, then to the erased page, then re-enable
        n = far.n_store_q;
        wr(flash_prog_pkg::OFS_PTR, 32'h0000_0180);
        op(flash_prog_pkg::OP_WRITE);
        chk(r[flash_prog_pkg::ST_ERR_PAGE], 1'b1, "page flag");
        chk(far.n_store_q, n, "no store on mismatch");
        wr(flash_prog_pkg::OFS_PTR, 32'h0000_015A);
        op(flash_prog_pkg::OP_WRITE);
        chk(far.wr_ptr_q, 16'h0100, "write pointer");
        chk(far.buf_q[5], 16'hFFFF, "buffer cleared");
        chk(r[flash_prog_pkg::ST_RWW], 1'b1, "rww busy held");
        op(flash_prog_pkg::OP_REEN);
        repeat (4) @(posedge pclk);
        rd(flash_prog_pkg::OFS_STAT);
        chk(r[flash_prog_pkg::ST_RWW], 1'b0, "rww busy cleared");
        $display("test page write done");
        // lock write then lock read
        wr(flash_prog_pkg::OFS_DATA, 32'h0000_0032);
        op(flash_prog_pkg::OP_LOCKW);
        chk(far.lock_q, 6'h32, "lock cells");
        chk(far.lk_ptr_q, 16'h0001, "lock pointer");
        chk(far.lk_lo_q, 8'hF2, "lock byte");
        op(flash_prog_pkg::OP_LOCKR);
        repeat (6) @(posedge pclk);
        rd(flash_prog_pkg::OFS_STAT);
        chk(r[15:8], 8'hF2, "lock readback");
        $display("test lock bits done");
        // command held off while eeprom write runs
        ee_busy <= 1'b1;
        wr(flash_prog_pkg::OFS_PTR, 32'h0000_0100);
        n = far.n_store_q;
        wr(flash_prog_pkg::OFS_CMD, {29'h0, flash_prog_pkg::OP_ERASE});
        repeat (20) @(posedge pclk);
        chk(far.n_store_q, n, "store held off");
        ee_busy <= 1'b0;
        idle();
        chk(far.n_store_q, n + 1, "store after eeprom");
        $display("test eeprom interlock done");
        stop_test();
    end
endmodule // testbench
